// ### design/fisc_pkg.sv
package fisc_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h8e;
  localparam logic [7:0] IDX_RESULT = 8'h8f;
  localparam logic [7:0] IDX_SETUP = 8'h9d;
  localparam logic [7:0] IDX_IEN = 8'ha9;
  localparam logic [7:0] IDX_IFLAG = 8'haa;
  localparam logic [7:0] IDX_IPRI = 8'hb9;
  localparam logic [7:0] IDX_PORT = 8'hc0;
  localparam logic [7:0] IDX_STATUS = 8'hc1;
  localparam logic [7:0] IDX_MASK = 8'hc2;

  localparam logic [9:0] ADR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADR_RESULT = {IDX_RESULT, 2'b00};
  localparam logic [9:0] ADR_SETUP = {IDX_SETUP, 2'b00};
  localparam logic [9:0] ADR_IEN = {IDX_IEN, 2'b00};
  localparam logic [9:0] ADR_IFLAG = {IDX_IFLAG, 2'b00};
  localparam logic [9:0] ADR_IPRI = {IDX_IPRI, 2'b00};
  localparam logic [9:0] ADR_PORT = {IDX_PORT, 2'b00};
  localparam logic [9:0] ADR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADR_MASK = {IDX_MASK, 2'b00};

  // field positions
  localparam int FLAG_BIT = 7;
  localparam int REPEAT_BIT = 6;
  localparam int DIV_LSB = 4;
  localparam int SEL_LSB = 2;
  localparam int APE_LSB = 4;
  localparam int PORT_LSB = 4;
  localparam int IRQ_BIT = 3;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_OVR_BIT = 1;

  // prescaler terminal counts for divide by 8, 16, 32, 64
  localparam logic [5:0] TERM_DIV8 = 6'h07;
  localparam logic [5:0] TERM_DIV16 = 6'h0f;
  localparam logic [5:0] TERM_DIV32 = 6'h1f;
  localparam logic [5:0] TERM_DIV64 = 6'h3f;

  // converter clock periods per conversion
  localparam logic [4:0] CONV_TICKS = 5'h14;

  typedef enum logic [0:0] {
    FISC_IDLE = 1'b0,
    FISC_CONV = 1'b1
  } fisc_state_t;

endpackage

// ### design/fisc_top.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
// How it works
// (R1) two-bit select routes one of four inputs
// (R2) completion loads result and sets finish flag
// (R3) finish flag cleared by control write, result read
// (R4) repeat mode converts back to back
// (R5) converter clock is oscillator over 8..64
// (R6) a conversion lasts twenty converter clocks
// (R7) selected enabled pin becomes analog input
// (R8) port writes skip the converter-held pin
// (R9) reading held pin returns port register
// (R10) pin enable bits make pins high impedance
// (R11) result code clamps at zero and full
// (R12) one interrupt request per finished conversion
// (R13) interrupt enable bit gates the request
// (R14) priority bit selects high or low level
// (R15) interrupt flag set, cleared after service
// (R16) result register read-only, zero after reset
// (R17) software keeps converter clock 500k..2.5M
// (R18) control write starts or restarts conversion
module fisc_top
  import fisc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic sample_irq_req,
  output logic sample_irq_high_prio,
  input wire logic sample_irq_ack,
  output logic ana_clk,
  output logic [1:0] ana_sel,
  output logic ana_active,
  input wire logic [7:0] ana_code,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic [3:0] pin_analog
);
  import fisc_pkg::*;

  typedef struct packed {
    logic wait_rq;
    logic [7:0] rdata;
    logic flag;
    logic repeat_mode;
    logic [1:0] sample_clk_div;
    logic [1:0] input_select;
    logic [7:0] result;
    logic [3:0] analog_pin_enable;
    logic irq_en;
    logic irq_pri;
    logic irq_flag;
    logic [3:0] port_data;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic sirq;
    logic sirq_hi;
    fisc_state_t state;
    logic [5:0] pre;
    logic [4:0] ticks;
    logic aclk;
    logic active;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic [3:0] pin_ana;
  } fisc_regs_t;

  localparam fisc_regs_t RST_VAL = '{wait_rq: 1'b1, state: FISC_IDLE, default: '0};

  fisc_regs_t st;
  fisc_regs_t nx;
  logic [3:0] taken;
  logic [3:0] port_rd;
  logic done;
  logic launch;

  function automatic logic [5:0] term_of(input logic [1:0] div);
    case (div)
      2'b00: term_of = TERM_DIV8;
      2'b01: term_of = TERM_DIV16;
      2'b10: term_of = TERM_DIV32;
      default: term_of = TERM_DIV64;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // port pins shared with the converter

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign taken[gi] = st.analog_pin_enable[gi] && (st.input_select == 2'(gi)); // [R7]
      assign port_rd[gi] = taken[gi] ? st.port_data[gi] : pin_in[gi]; // [R9]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic req;
    logic wr;
    logic rd;
    logic [7:0] rv;
    logic [7:0] wd;
    logic [5:0] term;
    logic rd_result;
    logic wr_ctrl;
    nx = st;
    req = avs_read | avs_write;
    wr = avs_write & ~st.wait_rq & avs_byteenable[0];
    rd = avs_read & ~st.wait_rq;
    wd = avs_writedata[7:0];
    term = term_of(st.sample_clk_div);
    rd_result = rd && (avs_address == ADR_RESULT);
    wr_ctrl = wr && (avs_address == ADR_CTRL);
    done = 1'b0;
    launch = 1'b0;

    // one wait state, then the request is taken
    nx.wait_rq = !(req && st.wait_rq);
    rv = 8'h00;
    case (avs_address)
      ADR_CTRL: begin
        rv[FLAG_BIT] = st.flag;
        rv[REPEAT_BIT] = st.repeat_mode;
        rv[DIV_LSB +: 2] = st.sample_clk_div;
        rv[SEL_LSB +: 2] = st.input_select;
      end
      ADR_RESULT: rv = st.result;
      ADR_SETUP: rv[APE_LSB +: 4] = st.analog_pin_enable;
      ADR_IEN: rv[IRQ_BIT] = st.irq_en;
      ADR_IFLAG: rv[IRQ_BIT] = st.irq_flag;
      ADR_IPRI: rv[IRQ_BIT] = st.irq_pri;
      ADR_PORT: rv[PORT_LSB +: 4] = port_rd; // [R9]
      ADR_STATUS: rv[1:0] = st.status;
      ADR_MASK: rv[1:0] = st.mask;
      default: rv = 8'h00;
    endcase
    if (req && st.wait_rq) begin
      nx.rdata = rv;
    end

    // conversion timing
    if (st.state == FISC_CONV) begin
      if (st.pre == term) begin
        nx.pre = 6'h00;
        if (st.ticks == CONV_TICKS - 5'h01) begin // [R6]
          done = 1'b1;
          nx.ticks = 5'h00;
          if (st.repeat_mode) begin // [R4]
            launch = 1'b1;
          end else begin
            nx.state = FISC_IDLE;
          end
        end else begin
          nx.ticks = st.ticks + 5'h01;
        end
      end else begin
        nx.pre = st.pre + 6'h01; // [R5]
      end
    end

    // register writes; result has no write path
    if (wr) begin
      case (avs_address)
        ADR_CTRL: begin
          nx.repeat_mode = wd[REPEAT_BIT]; // [R4]
          nx.sample_clk_div = wd[DIV_LSB +: 2]; // [R5]
          nx.input_select = wd[SEL_LSB +: 2]; // [R1]
        end
        ADR_SETUP: nx.analog_pin_enable = wd[APE_LSB +: 4]; // [R10]
        ADR_IEN: nx.irq_en = wd[IRQ_BIT]; // [R13]
        ADR_IPRI: nx.irq_pri = wd[IRQ_BIT]; // [R14]
        ADR_PORT: begin
          for (int i = 0; i < 4; i++) begin
            if (!taken[i]) begin
              nx.port_data[i] = wd[PORT_LSB + i]; // [R8]
            end
          end
        end
        ADR_STATUS: nx.status = st.status & ~wd[1:0];
        ADR_MASK: nx.mask = wd[1:0];
        default: nx.mask = nx.mask;
      endcase
    end

    // clears first so a completion in the same cycle wins
    if (wr_ctrl || rd_result) begin
      nx.flag = 1'b0; // [R3]
    end
    if (sample_irq_ack) begin
      nx.irq_flag = 1'b0; // [R15]
    end

    if (wr_ctrl) begin
      launch = 1'b1; // [R18]
      nx.state = FISC_CONV;
      nx.pre = 6'h00;
      nx.ticks = 5'h00;
    end

    if (done) begin
      nx.result = ana_code; // [R2] [R11]
      nx.flag = 1'b1; // [R2]
      nx.irq_flag = 1'b1; // [R12] [R15]
      nx.status[ST_DONE_BIT] = 1'b1;
      if (st.flag && !rd_result) begin
        nx.status[ST_OVR_BIT] = 1'b1;
      end
    end

    nx.irq = |(nx.status & nx.mask);
    nx.sirq = nx.irq_flag & nx.irq_en; // [R13]
    nx.sirq_hi = nx.irq_pri; // [R14]
    nx.active = (nx.state == FISC_CONV);
    nx.aclk = nx.active && (nx.pre > (term_of(nx.sample_clk_div) >> 1)); // [R5]
    for (int i = 0; i < 4; i++) begin
      nx.pin_oe_n[i] = nx.analog_pin_enable[i]; // [R10]
      nx.pin_out[i] = nx.port_data[i];
      nx.pin_ana[i] = nx.analog_pin_enable[i] && (nx.input_select == 2'(i)); // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= RST_VAL; // [R16]
    end else begin
      st <= nx;
    end
  end

  assign avs_readdata = {24'h000000, st.rdata};
  assign avs_waitrequest = st.wait_rq;
  assign irq = st.irq;
  assign sample_irq_req = st.sirq;
  assign sample_irq_high_prio = st.sirq_hi;
  assign ana_clk = st.aclk;
  assign ana_sel = st.input_select; // [R1]
  assign ana_active = st.active;
  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign pin_analog = st.pin_ana;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [11:0] conv_cyc;
  always_ff @(posedge clk) begin
    if (reset || launch) begin
      conv_cyc <= 12'h000;
    end else begin
      conv_cyc <= conv_cyc + 12'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic ctrl_wr_t;
  logic res_rd_t;
  logic port_wr_t;
  assign ctrl_wr_t = avs_write && !avs_waitrequest && avs_byteenable[0]
                     && (avs_address == ADR_CTRL);
  assign res_rd_t = avs_read && !avs_waitrequest && (avs_address == ADR_RESULT);
  assign port_wr_t = avs_write && !avs_waitrequest && avs_byteenable[0]
                     && (avs_address == ADR_PORT);

  AST_SEL_ROUTE: assert property (ctrl_wr_t |=> ana_sel == $past(avs_writedata[3:2])) // [R1]
    else $error("selected input does not follow control write");
  AST_DONE_LOAD: assert property (done |=> st.flag && st.result == $past(ana_code)) // [R2]
    else $error("completion did not load result and flag");
  AST_CLEAR: assert property ((ctrl_wr_t || res_rd_t) && !done |=> !st.flag) // [R3]
    else $error("finish flag survived a clearing access");
  AST_SINGLE: assert property (done && !st.repeat_mode && !ctrl_wr_t
                               |=> !ana_active [*3]) // [R4]
    else $error("single mode kept converting");
  AST_DIV_RANGE: assert property (ana_active |-> st.pre <= term_of(st.sample_clk_div)) // [R5]
    else $error("prescaler passed its terminal count");
  AST_CONV_LEN: assert property (done |-> conv_cyc ==
      12'(20 * (int'(term_of(st.sample_clk_div)) + 1) - 1)) // [R6]
    else $error("conversion length is not twenty converter clocks");
  AST_PIN_HIZ: assert property (pin_analog != 4'h0 |-> (pin_analog & ~pin_oe_n) == 4'h0) // [R10]
    else $error("analog pin still driven");
  AST_PORT_KEEP: assert property (port_wr_t && taken != 4'h0
      |=> (st.port_data & $past(taken)) == ($past(st.port_data) & $past(taken))) // [R8]
    else $error("port write changed the converter pin");
  AST_IRQ_GATE: assert property (done && st.irq_en && !sample_irq_ack
      |=> ##1 sample_irq_req) // [R12]
    else $error("enabled completion raised no request");
  AST_IRQ_BLOCK: assert property (!nx.irq_en |=> !sample_irq_req) // [R13]
    else $error("request raised while disabled");

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake and register behaviour

  AST_WAIT_IDLE: assert property (!(avs_read || avs_write)
    |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  AST_WAIT_ONE: assert property (!avs_waitrequest
    |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  AST_RDATA_HI: assert property (
    avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  AST_RES_HOLD: assert property (!done // [R16]
    |=> st.result == $past(st.result))
    else $error("result changed without a completion");

  AST_FLAG_RISE: assert property (!st.flag && !done // [R2]
    |=> !st.flag)
    else $error("finish flag set without a completion");

  ////////////////////////////////////////////////////////////////////////////
  // conversion, pins and interrupt

  AST_REPEAT_GO: assert property (done && st.repeat_mode // [R4]
    |=> ana_active)
    else $error("repeat mode stopped after a completion");

  AST_RESTART: assert property (ctrl_wr_t // [R18]
    |=> ana_active && st.ticks == 5'h00 && st.pre == 6'h00)
    else $error("control write did not restart the conversion");

  AST_ACLK_IDLE: assert property (!ana_active // [R5]
    |-> !ana_clk)
    else $error("converter clock runs while idle");

  AST_PIN_ONE: assert property ( // [R7]
    $onehot0(pin_analog))
    else $error("more than one pin given to the converter");

  AST_PIN_SEL: assert property (pin_analog != 4'h0 // [R1]
    |-> pin_analog == (4'h1 << ana_sel))
    else $error("converter pin differs from the selected input");

  AST_IRQ_LEVEL: assert property (
    irq == |(st.status & st.mask))
    else $error("interrupt line disagrees with status and mask");

  AST_PRIO: assert property ( // [R14]
    sample_irq_high_prio == st.irq_pri)
    else $error("priority output disagrees with its bit");

  AST_IFLAG_SET: assert property (done // [R15]
    |=> st.irq_flag)
    else $error("completion did not set the interrupt flag");

  AST_IFLAG_CLR: assert property (sample_irq_ack && !done // [R15]
    |=> !st.irq_flag)
    else $error("interrupt flag survived the service");

  COV_REPEAT: cover property (done && st.repeat_mode ##[1:1000] done);
  COV_READ_CLR: cover property (done ##[1:100] res_rd_t);
  COV_RESTART: cover property (ana_active && ctrl_wr_t);
  COV_OVERRUN: cover property (st.status[ST_OVR_BIT]);

endmodule

// ### test/fisc_ana_model.sv
`timescale 1ns/100ps
module fisc_ana_model (
  input wire logic clk,
  input wire logic ana_active,
  input wire logic [1:0] ana_sel,
  input wire logic [9:0] lvl [4],
  output logic [7:0] ana_code
);
  logic [7:0] last = 8'h00;
  always_ff @(posedge clk) begin
    last <= ana_code;
  end
  // idle: inverse of last code; active: level clamped to full scale
  assign ana_code = !ana_active ? ~last :
    (lvl[ana_sel] > 10'h0ff) ? 8'hff : lvl[ana_sel][7:0];
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
  import fisc_pkg::*;
  logic clk = 0, reset = 1, rd = 0, wr = 0, ack = 0, waitreq, irq, sreq, sprio;
  logic ana_clk, ana_active;
  logic [1:0] ana_sel;
  logic [3:0] be = 4'hf, pin_in = 4'h0, pin_out, pin_oe_n, pin_analog;
  logic [7:0] ana_code, got, c;
  logic [9:0] adr = 10'h000;
  logic [9:0] lvl [4];
  logic [31:0] wd = 32'h0, rdata;
  logic [8:0] expq [$];
  logic [9:0] ra [6] = '{ADR_RESULT, ADR_CTRL, ADR_SETUP, ADR_IEN, ADR_IPRI, 10'h000};
  int mismatches = 0, tests_run = 0, seed = 32'h9cbbaaca, cyc = 0, n;

  fisc_top fisc_top_inst (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .irq(irq), .sample_irq_req(sreq),
    .sample_irq_high_prio(sprio), .sample_irq_ack(ack), .ana_clk(ana_clk),
    .ana_sel(ana_sel), .ana_active(ana_active), .ana_code(ana_code), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_analog(pin_analog));
  fisc_ana_model fisc_ana_model_inst (.clk(clk), .ana_active(ana_active),
    .ana_sel(ana_sel), .lvl(lvl), .ana_code(ana_code));

  initial begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // bit 8 of a note: value not checked
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
    input logic [8:0] e);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    if (!w) expq.push_back(e);
    do @(posedge clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 9'h100);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, {1'b0, e});
  endtask

  function automatic logic [7:0] clamp(input logic [9:0] v);
    return (v > 10'h0ff) ? 8'hff : v[7:0];
  endfunction

  // start a conversion, count cycles while active
  task automatic conv(input logic [7:0] cv, output int k);
    wrr(ADR_CTRL, cv);
    k = 1;
    forever begin
      #1;
      if (!ana_active || k > 2000) break;
      k++;
      @(posedge clk);
    end
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 10000) begin
      mismatches++;
      stop_test();
    end
    if (rd && !waitreq) begin
      got = expq[0][7:0];
      if (!expq[0][8]) chk(got, rdata[7:0]);
      void'(expq.pop_front());
    end
  end

  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4; i++) lvl[i] = 10'($random(seed));
    lvl[3] = 10'h3c0;
    pin_in = 4'($random(seed)) | 4'h2;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) rdc(ra[i], 8'h00);
    wrr(ADR_RESULT, 8'h5a);
    rdc(ADR_RESULT, 8'h00);
    wrr(ADR_SETUP, 8'hf0);
    rdc(ADR_SETUP, 8'hf0);
    chk({4'h0, pin_oe_n}, 8'h0f);
    wrr(ADR_IPRI, 8'h08);
    chk({7'h0, sprio}, 8'h01);
    be <= 4'he;
    wrr(ADR_IEN, 8'h08);
    be <= 4'hf;
    rdc(ADR_IEN, 8'h00);
    wrr(ADR_IEN, 8'h08);
    wrr(ADR_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      c = {2'b00, 2'(i), 2'(i), 2'b00};
      if (i == 0) wrr(ADR_CTRL, c); // 1.25 MHz converter clock
      if (i == 0) repeat (50) @(posedge clk);
      conv(c, n);
      chk(8'((n - 20 * (8 << i)) inside {0, 1}), 8'h01);
      chk({6'h0, ana_sel}, 8'(i));
      chk({4'h0, pin_analog}, 8'(1 << i));
      chk({6'h0, irq, sreq}, 8'h03);
      rdc(ADR_CTRL, c | 8'h80);
      rdc(ADR_IFLAG, 8'h08);
      rdc(ADR_RESULT, clamp(lvl[i]));
      rdc(ADR_CTRL, c);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      wrr(ADR_STATUS, 8'h03);
      repeat (2) @(posedge clk);
      chk({6'h0, irq, sreq}, 8'h00);
    end
    wrr(ADR_CTRL, 8'h44);
    repeat (400) @(posedge clk);
    chk({7'h0, ana_active}, 8'h01);
    rdc(ADR_STATUS, 8'h03);
    wrr(ADR_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    lvl[1] = 10'($random(seed));
    repeat (400) @(posedge clk);
    rdc(ADR_RESULT, clamp(lvl[1]));
    wrr(ADR_CTRL, 8'h04);
    repeat (200) @(posedge clk);
    chk({6'h0, ana_active, ana_clk}, 8'h00);
    wrr(ADR_PORT, 8'hf0);
    chk({4'h0, pin_out}, 8'h0d);
    wrr(ADR_PORT, 8'hd0);
    rdc(ADR_PORT, {pin_in & 4'hd, 4'h0});
    stop_test();
  end
endmodule
